//--- inc/cidec_pkg.sv
// Purpose: shared constants and types for the custom instruction word decoder
// Assumes: 32-bit register-format instruction words, classic Wishbone register access
// Notes: all field positions and offsets live here, and the reset values of the control and count registers
// Summary of operation
// - custom operations are register-format words recognised by opcode 0x32
// - select index is taken from bits 13:6 and chooses the operation
// - up to 256 custom operations through one opcode, over several components
// - selector 0 means component internal registers, 1 means processor registers
// - readra, readrb and writerc selector bits are passed to the component
// - three register address fields name operands A, B and result C
// - processor registers A and B feed the operands, result goes to C
// - a plain component gets a fixed 8-bit select index at instantiation
// - a multi-operation component gets an extension index from the select index
// - extension index up to 8 bits, taken from the low select bits
package cidec_pkg;

   // instruction word layout
   localparam int CIDEC_A_HI = 31;
   localparam int CIDEC_A_LO = 27;
   localparam int CIDEC_B_HI = 26;
   localparam int CIDEC_B_LO = 22;
   localparam int CIDEC_C_HI = 21;
   localparam int CIDEC_C_LO = 17;
   localparam int CIDEC_READRA_BIT = 16;
   localparam int CIDEC_READRB_BIT = 15;
   localparam int CIDEC_WRITERC_BIT = 14;
   localparam int CIDEC_N_HI = 13;
   localparam int CIDEC_N_LO = 6;
   localparam int CIDEC_OPC_HI = 5;
   localparam int CIDEC_OPC_LO = 0;
   localparam logic [5:0] CIDEC_OPCODE_CUSTOM = 6'h32;

   // register file selector encoding
   localparam logic CIDEC_SEL_INTERNAL = 1'h0;
   localparam logic CIDEC_SEL_PROCESSOR = 1'h1;

   // component binding defaults
   localparam logic [7:0] CIDEC_SELECT_BASE = 8'h00;
   localparam int CIDEC_EXT_BITS = 2;

   // register map, byte addresses
   localparam logic [7:0] CIDEC_OFS_CTRL = 8'h00;
   localparam logic [7:0] CIDEC_OFS_STATUS = 8'h04;
   localparam logic [7:0] CIDEC_OFS_COUNT = 8'h08;
   localparam logic [7:0] CIDEC_OFS_REGIDX = 8'h0C;
   localparam logic [7:0] CIDEC_OFS_REGDATA = 8'h10;
   localparam int CIDEC_CTRL_EN_BIT = 0;
   localparam int CIDEC_ST_BUSY_BIT = 8;
   localparam int CIDEC_ST_MISS_BIT = 9;
   localparam logic CIDEC_CTRL_EN_RST = 1'h1;
   localparam logic [15:0] CIDEC_COUNT_RST = 16'h0000;

   // decoded instruction fields
   typedef struct packed {
      logic [4:0] a;
      logic [4:0] b;
      logic [4:0] c;
      logic readra;
      logic readrb;
      logic writerc;
      logic [7:0] n;
      logic [5:0] opcodeField;
   } cidec_fields_type;

   // request bundle towards the custom component
   typedef struct packed {
      logic start;
      logic [7:0] n;
      logic readra;
      logic readrb;
      logic writerc;
      logic [4:0] a;
      logic [4:0] b;
      logic [4:0] c;
      logic [31:0] dataa;
      logic [31:0] datab;
   } cidec_ci_req_type;

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_WB} cidec_state_type;

endpackage : cidec_pkg

//--- hdl/cidec_field_split.sv
// Purpose: splits a register-format instruction word into its fields
// Assumes: purely combinational, same clock domain as the caller
// Notes: also flags whether the opcode names a custom operation
`timescale 1ns/1ps
module cidec_field_split (
   input wire logic [31:0] instrWord,
   output cidec_pkg::cidec_fields_type fields,
   output logic isCustom
);

   // field extraction
   assign fields.a = instrWord[cidec_pkg::CIDEC_A_HI:cidec_pkg::CIDEC_A_LO];
   assign fields.b = instrWord[cidec_pkg::CIDEC_B_HI:cidec_pkg::CIDEC_B_LO];
   assign fields.c = instrWord[cidec_pkg::CIDEC_C_HI:cidec_pkg::CIDEC_C_LO];
   assign fields.readra = instrWord[cidec_pkg::CIDEC_READRA_BIT];
   assign fields.readrb = instrWord[cidec_pkg::CIDEC_READRB_BIT];
   assign fields.writerc = instrWord[cidec_pkg::CIDEC_WRITERC_BIT];
   assign fields.n = instrWord[cidec_pkg::CIDEC_N_HI:cidec_pkg::CIDEC_N_LO];
   assign fields.opcodeField = instrWord[cidec_pkg::CIDEC_OPC_HI:cidec_pkg::CIDEC_OPC_LO];

   // custom opcode recognition
   assign isCustom = (fields.opcodeField == cidec_pkg::CIDEC_OPCODE_CUSTOM);

endmodule : cidec_field_split

//--- hdl/cidec_decoder.sv
// Purpose: custom instruction word decoder and dispatcher with processor register file
// Assumes: instruction issue and component answer on the core clock, Wishbone classic slave
// Notes: one instruction in flight; the component answers with ciDone and ciResult
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cidec_decoder #(
   parameter logic [7:0] SELECT_BASE = cidec_pkg::CIDEC_SELECT_BASE,
   parameter int EXT_BITS = cidec_pkg::CIDEC_EXT_BITS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clkEn,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // instruction issue from the core
   input wire logic instrValid,
   input wire logic [31:0] instrWord,
   output logic instrReady,
   output logic instrDone,
   output logic instrMiss,
   // custom component side
   output cidec_pkg::cidec_ci_req_type ciReq,
   input wire logic ciDone,
   input wire logic [31:0] ciResult
);

   // mask of select bits handed over as extension index
   localparam logic [7:0] EXT_MASK = 8'((9'h001 << EXT_BITS) - 9'h001);

   // byte-lane merge for partial bus writes
   function automatic logic [31:0] byteMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] sel);
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction : byteMerge

   // component select match on the bits above the extension index
   function automatic logic selectHit(input logic [7:0] n);
      return (n & ~EXT_MASK) == (SELECT_BASE & ~EXT_MASK);
   endfunction : selectHit

   // operand source: processor register or zero when the component supplies it
   function automatic logic [31:0] operandPick(input logic sel, input logic [31:0] regVal);
      return (sel == cidec_pkg::CIDEC_SEL_PROCESSOR) ? regVal : 32'h00000000;
   endfunction : operandPick

   // state
   cidec_pkg::cidec_state_type state_ff;
   cidec_pkg::cidec_state_type nxt_state;
   cidec_pkg::cidec_fields_type instr_ff;
   cidec_pkg::cidec_ci_req_type ciReq_ff;
   cidec_pkg::cidec_ci_req_type nxt_ciReq;
   logic [31:0] regFile [32];
   logic [31:0] result_ff;
   logic ctrlEn_ff;
   logic [4:0] regIdx_ff;
   logic [15:0] count_ff;
   logic [7:0] lastSel_ff;
   logic lastMiss_ff;
   logic instrReady_ff;
   logic instrDone_ff;
   logic instrMiss_ff;
   logic [31:0] wbDat_ff;
   logic wbAck_ff;

   // decoded view of the incoming word
   cidec_pkg::cidec_fields_type fields;
   logic isCustom;

   cidec_field_split cidec_field_split_i (
      .instrWord(instrWord),
      .fields(fields),
      .isCustom(isCustom)
   );

   // issue acceptance and dispatch decision
   wire logic accept = instrValid && instrReady_ff && (state_ff == cidec_pkg::ST_IDLE);
   wire logic hit = isCustom && selectHit(fields.n) && ctrlEn_ff;
   wire logic dispatch = accept && hit;
   wire logic reject = accept && !hit;
   wire logic answerSeen = ciDone && ((state_ff == cidec_pkg::ST_ISSUE) || (state_ff == cidec_pkg::ST_WAIT));
   // processor register write only when the result selector names it
   wire logic wbWrite = (state_ff == cidec_pkg::ST_WB) &&
                        (instr_ff.writerc == cidec_pkg::CIDEC_SEL_PROCESSOR);

   // bus decode
   wire logic busReq = wb_cyc_i && wb_stb_i && !wbAck_ff;
   wire logic busWr = busReq && wb_we_i;
   wire logic selCtrl = (wb_adr_i == cidec_pkg::CIDEC_OFS_CTRL);
   wire logic selStatus = (wb_adr_i == cidec_pkg::CIDEC_OFS_STATUS);
   wire logic selCount = (wb_adr_i == cidec_pkg::CIDEC_OFS_COUNT);
   wire logic selIdx = (wb_adr_i == cidec_pkg::CIDEC_OFS_REGIDX);
   wire logic selData = (wb_adr_i == cidec_pkg::CIDEC_OFS_REGDATA);
   wire logic busRegWr = busWr && selData && !wbWrite;

   // read-back words
   wire logic [31:0] ctrlWord = {31'h00000000, ctrlEn_ff};
   wire logic [31:0] statusWord = {22'h000000, lastMiss_ff, (state_ff != cidec_pkg::ST_IDLE), lastSel_ff};
   wire logic [31:0] countWord = {16'h0000, count_ff};
   wire logic [31:0] idxWord = {27'h0000000, regIdx_ff};
   wire logic [31:0] nxt_wbDat = selCtrl ? ctrlWord :
                                 selStatus ? statusWord :
                                 selCount ? countWord :
                                 selIdx ? idxWord :
                                 selData ? regFile[regIdx_ff] :
                                 32'h00000000;
   wire logic [31:0] ctrlMerged = byteMerge(ctrlWord, wb_dat_i, wb_sel_i);
   wire logic [31:0] idxMerged = byteMerge(idxWord, wb_dat_i, wb_sel_i);
   wire logic [31:0] dataMerged = byteMerge(regFile[regIdx_ff], wb_dat_i, wb_sel_i);

   // next state of the dispatch sequence
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         cidec_pkg::ST_IDLE: begin
            if (dispatch) begin
               nxt_state = cidec_pkg::ST_ISSUE;
            end
         end
         cidec_pkg::ST_ISSUE: begin
            nxt_state = ciDone ? cidec_pkg::ST_WB : cidec_pkg::ST_WAIT;
         end
         cidec_pkg::ST_WAIT: begin
            if (ciDone) begin
               nxt_state = cidec_pkg::ST_WB;
            end
         end
         cidec_pkg::ST_WB: begin
            nxt_state = cidec_pkg::ST_IDLE;
         end
      endcase
   end

   // request bundle for the component, loaded on dispatch, start for one cycle
   always_comb begin
      nxt_ciReq = ciReq_ff;
      nxt_ciReq.start = 1'b0;
      if (dispatch) begin
         nxt_ciReq.start = 1'b1;
         nxt_ciReq.n = fields.n & EXT_MASK;
         nxt_ciReq.readra = fields.readra;
         nxt_ciReq.readrb = fields.readrb;
         nxt_ciReq.writerc = fields.writerc;
         nxt_ciReq.a = fields.a;
         nxt_ciReq.b = fields.b;
         nxt_ciReq.c = fields.c;
         nxt_ciReq.dataa = operandPick(fields.readra, regFile[fields.a]);
         nxt_ciReq.datab = operandPick(fields.readrb, regFile[fields.b]);
      end
   end

   // sequence state and request register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= cidec_pkg::ST_IDLE;
         ciReq_ff <= '0;
         instr_ff <= '0;
      end else if (clkEn) begin
         state_ff <= nxt_state;
         ciReq_ff <= nxt_ciReq;
         if (dispatch) begin
            instr_ff <= fields;
         end
      end
   end

   // result capture from the component
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_ff <= 32'h00000000;
      end else if (clkEn && answerSeen) begin
         result_ff <= ciResult;
      end
   end

   // processor register file; write-back wins over a bus write in the same cycle
   always_ff @(posedge clock) begin
      if (clkEn) begin
         if (wbWrite) begin
            regFile[instr_ff.c] <= result_ff;
         end else if (busRegWr) begin
            regFile[regIdx_ff] <= dataMerged;
         end
      end
   end

   // handshake towards the core
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         instrReady_ff <= 1'b0;
         instrDone_ff <= 1'b0;
         instrMiss_ff <= 1'b0;
      end else if (clkEn) begin
         instrReady_ff <= (nxt_state == cidec_pkg::ST_IDLE) && !dispatch;
         instrDone_ff <= reject || (state_ff == cidec_pkg::ST_WB);
         instrMiss_ff <= reject;
      end
   end

   // status tracking: last select index, miss flag and execution count
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lastSel_ff <= 8'h00;
         lastMiss_ff <= 1'b0;
         count_ff <= cidec_pkg::CIDEC_COUNT_RST;
      end else if (clkEn) begin
         if (accept) begin
            lastSel_ff <= fields.n;
            lastMiss_ff <= !hit;
         end
         if (state_ff == cidec_pkg::ST_WB) begin
            count_ff <= count_ff + 16'h0001;
         end
      end
   end

   // software control registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrlEn_ff <= cidec_pkg::CIDEC_CTRL_EN_RST;
         regIdx_ff <= 5'h00;
      end else if (clkEn) begin
         if (busWr && selCtrl) begin
            ctrlEn_ff <= ctrlMerged[cidec_pkg::CIDEC_CTRL_EN_BIT];
         end
         if (busWr && selIdx) begin
            regIdx_ff <= idxMerged[4:0];
         end
      end
   end

   // bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wbAck_ff <= 1'b0;
         wbDat_ff <= 32'h00000000;
      end else if (clkEn) begin
         wbAck_ff <= busReq;
         if (busReq && !wb_we_i) begin
            wbDat_ff <= nxt_wbDat;
         end
      end
   end

   // outputs straight from flip-flops
   assign wb_dat_o = wbDat_ff;
   assign wb_ack_o = wbAck_ff;
   assign instrReady = instrReady_ff;
   assign instrDone = instrDone_ff;
   assign instrMiss = instrMiss_ff;
   assign ciReq = ciReq_ff;

endmodule : cidec_decoder

//--- sim/cidec_decoder_chk.sv
// Purpose: port-level checks for the custom instruction decoder
// Assumes: one core clock, asynchronous active-low reset, clkEn high while checked
// Notes: bound to every cidec_decoder instance at the foot of this file
`timescale 1ns/1ps
module cidec_decoder_chk #(
   parameter logic [7:0] SELECT_BASE = 8'h00,
   parameter int EXT_BITS = 2
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic instrValid,
   input wire logic [31:0] instrWord,
   input wire logic instrReady,
   input wire logic instrDone,
   input wire logic instrMiss,
   input wire cidec_pkg::cidec_ci_req_type ciReq,
   input wire logic ciDone
);
   localparam logic [7:0] EXT_MASK = 8'((1 << EXT_BITS) - 1);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // word taken by the decoder, and dispatch seen one cycle later
   sequence s_take;
      instrValid && instrReady && clkEn;
   endsequence
   sequence s_start;
      ciReq.start && $past(clkEn);
   endsequence
   property p_ack_pulse;
      wb_ack_o && clkEn |=> !wb_ack_o;
   endproperty
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o;
   endproperty
   property p_reject_op;
      s_take ##0 (instrWord[5:0] != cidec_pkg::CIDEC_OPCODE_CUSTOM) |=> instrDone && instrMiss && !ciReq.start;
   endproperty
   property p_reject_sel;
      s_take ##0 ((instrWord[13:6] & ~EXT_MASK) != (SELECT_BASE & ~EXT_MASK)) |=> instrMiss;
   endproperty
   property p_fields;
      s_start |-> ciReq.a == $past(instrWord[31:27]) && ciReq.b == $past(instrWord[26:22])
         && ciReq.c == $past(instrWord[21:17]);
   endproperty
   property p_selectors;
      s_start |-> {ciReq.readra, ciReq.readrb, ciReq.writerc} == $past(instrWord[16:14]);
   endproperty
   property p_ext;
      s_start |-> ciReq.n == ($past(instrWord[13:6]) & EXT_MASK);
   endproperty
   property p_zero_op;
      s_start |-> (ciReq.readra || ciReq.dataa == '0) && (ciReq.readrb || ciReq.datab == '0);
   endproperty
   property p_busy;
      s_start |-> !instrReady ##1 !ciReq.start;
   endproperty
   property p_finish;
      !instrReady && ciDone && clkEn && !instrDone |-> ##2 instrDone && !instrMiss;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged");
   a_reject_op: assert property (p_reject_op) else $error("foreign opcode not rejected");
   a_reject_sel: assert property (p_reject_sel) else $error("foreign select not rejected");
   a_fields: assert property (p_fields) else $error("register address fields wrong");
   a_selectors: assert property (p_selectors) else $error("selector bits wrong");
   a_ext: assert property (p_ext) else $error("extension index wrong");
   a_zero_op: assert property (p_zero_op) else $error("internal operand not zero");
   a_busy: assert property (p_busy) else $error("ready during dispatch");
   a_finish: assert property (p_finish) else $error("done late after answer");
endmodule : cidec_decoder_chk

bind cidec_decoder cidec_decoder_chk #(.SELECT_BASE(SELECT_BASE), .EXT_BITS(EXT_BITS)) cidec_decoder_chk_i (
   .clock(clock), .rstn(rstn), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
   .instrDone(instrDone), .instrMiss(instrMiss), .ciReq(ciReq), .ciDone(ciDone));

//--- sim/cidec_ci_model.sv
// Purpose: behavioural custom operation component, result = A + B + n
// Assumes: answers lag cycles after start, lag 0 answers in the start cycle
// Notes: keeps a small internal register file for selector value 0
`timescale 1ns/1ps
module cidec_ci_model (
   input wire logic clock,
   input wire logic rstn,
   input wire cidec_pkg::cidec_ci_req_type ciReq,
   input wire logic [1:0] lag,
   output logic ciDone,
   output logic [31:0] ciResult
);
   logic [1:0] cnt_ff;
   logic busy_ff;
   logic [31:0] pat_ff;
   logic [31:0] intReg [32];
   logic [31:0] opA;
   logic [31:0] opB;
   logic [31:0] sum;
   // internal operand only when the word selects it
   assign opA = ciReq.readra ? ciReq.dataa : intReg[ciReq.a];
   assign opB = ciReq.readrb ? ciReq.datab : intReg[ciReq.b];
   assign sum = opA + opB + {24'h0, ciReq.n};
   assign ciDone = (ciReq.start && lag == 2'h0) || (busy_ff && cnt_ff == 2'h1);
   // idle result bus toggles so a stale value is never taken
   assign ciResult = ciDone ? sum : ~pat_ff;
   // lag counter and internal write-back
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_ff <= 1'b0;
         cnt_ff <= 2'h0;
         pat_ff <= 32'h0;
      end else begin
         pat_ff <= pat_ff + 32'h1;
         if (ciReq.start && lag != 2'h0) begin
            busy_ff <= 1'b1;
            cnt_ff <= lag;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 2'h1;
            busy_ff <= cnt_ff != 2'h1;
         end
         if (ciDone && !ciReq.writerc) intReg[ciReq.c] <= sum;
      end
   end
endmodule : cidec_ci_model

//--- sim/custom_instr_word_decode_tb.sv
// Purpose: self-checking bench for the custom instruction decoder
// Assumes: 200 MHz clock, SELECT_BASE 0 and two extension bits
// Notes: processor registers are loaded and read through the Wishbone port
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module custom_instr_word_decode_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, instrValid = 1'b0, instrReady, instrDone, instrMiss;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbWdat = 32'h0, wbRdat, instrWord = 32'h0, ciResult, rd;
   logic [1:0] lag = 2'h0;
   logic ciDone;
   cidec_pkg::cidec_ci_req_type ciReq, seenReq;
   int fails = 0;
   int cmp_count = 0;
   always #2.5 clock = ~clock;
   cidec_decoder cidec_decoder_i (.clock(clock), .rstn(rstn), .clkEn(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbWdat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
      .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady), .instrDone(instrDone),
      .instrMiss(instrMiss), .ciReq(ciReq), .ciDone(ciDone), .ciResult(ciResult));
   cidec_ci_model cidec_ci_model_i (.clock(clock), .rstn(rstn), .ciReq(ciReq), .lag(lag), .ciDone(ciDone),
      .ciResult(ciResult));
   // remember the last dispatch for field checks
   always @(posedge clock) if (ciReq.start === 1'b1) seenReq <= ciReq;
   task automatic conclude();
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbWdat <= d;
      k = 0;
      do begin @(posedge clock); k++; end while (wbAck !== 1'b1 && k < 50);
      if (wbAck !== 1'b1) begin fails++; conclude(); end
      r = wbRdat;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb
   task automatic setReg(input logic [4:0] i, input logic [31:0] v);
      wb(1'b1, cidec_pkg::CIDEC_OFS_REGIDX, {27'h0, i}, rd);
      wb(1'b1, cidec_pkg::CIDEC_OFS_REGDATA, v, rd);
   endtask : setReg
   task automatic getReg(input logic [4:0] i, output logic [31:0] v);
      wb(1'b1, cidec_pkg::CIDEC_OFS_REGIDX, {27'h0, i}, rd);
      wb(1'b0, cidec_pkg::CIDEC_OFS_REGDATA, 32'h0, v);
   endtask : getReg
   task automatic issue(input logic [31:0] w, input logic expMiss);
      int k;
      k = 0;
      do begin @(posedge clock); k++; end while (instrReady !== 1'b1 && k < 50);
      if (instrReady !== 1'b1) begin fails++; conclude(); end
      instrValid <= 1'b1;
      instrWord <= w;
      @(posedge clock);
      instrValid <= 1'b0;
      do begin @(posedge clock); k++; end while (instrDone !== 1'b1 && k < 100);
      if (instrDone !== 1'b1) begin fails++; conclude(); end
      `CHK("miss", expMiss, instrMiss)
   endtask : issue
   // word layout: A, B, C, three selectors, select index, opcode
   function automatic logic [31:0] mk(logic [7:0] n, logic [4:0] c, logic [4:0] a, logic [4:0] b, logic [2:0] s,
      logic [5:0] op);
      return {a, b, c, s, n, op};
   endfunction : mk
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      wb(1'b0, cidec_pkg::CIDEC_OFS_CTRL, 32'h0, rd);
      `CHK("ctrl", 32'h1, rd)
      wb(1'b0, cidec_pkg::CIDEC_OFS_COUNT, 32'h0, rd);
      `CHK("count", 32'h0, rd)
      wb(1'b1, 8'h20, 32'hFFFFFFFF, rd);
      wb(1'b0, 8'h20, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      setReg(5'h07, 32'h5);
      setReg(5'h08, 32'h9);
      setReg(5'h01, 32'hAA);
      setReg(5'h02, 32'h7);
      for (int i = 0; i < 4; i++) begin
         lag <= 2'(i);
         issue(mk(8'(i), 5'h06, 5'h07, 5'h08, 3'h7, 6'h32), 1'b0);
         `CHK("ext", 8'(i), seenReq.n)
         getReg(5'h06, rd);
         `CHK("r6", 32'hE + 32'(i), rd)
      end
      issue(mk(8'h03, 5'h01, 5'h02, 5'h04, 3'h4, 6'h32), 1'b0);
      `CHK("opa", 32'h7, seenReq.dataa)
      `CHK("opb", 32'h0, seenReq.datab)
      getReg(5'h01, rd);
      `CHK("r1", 32'hAA, rd)
      issue(mk(8'h04, 5'h06, 5'h07, 5'h08, 3'h7, 6'h32), 1'b1);
      wb(1'b0, cidec_pkg::CIDEC_OFS_STATUS, 32'h0, rd);
      `CHK("status", 32'h00000204, rd)
      issue(mk(8'h00, 5'h06, 5'h07, 5'h08, 3'h7, 6'h31), 1'b1);
      wb(1'b1, cidec_pkg::CIDEC_OFS_CTRL, 32'h0, rd);
      issue(mk(8'h00, 5'h06, 5'h07, 5'h08, 3'h7, 6'h32), 1'b1);
      wb(1'b1, cidec_pkg::CIDEC_OFS_CTRL, 32'h1, rd);
      wb(1'b0, cidec_pkg::CIDEC_OFS_COUNT, 32'h0, rd);
      `CHK("count", 32'h5, rd)
      conclude();
   end
   // watchdog against a hung run
   initial begin
      #100000;
      fails++;
      conclude();
   end
endmodule : custom_instr_word_decode_tb
